// ==== shared/backlight_pkg.sv ====
// package: register map, field layout, reset values and timing of the backlight control
package backlight_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ENABLE_CONTROL_ADDR = 8'h10;
  localparam logic [7:0] BRIGHTNESS_CONFIG_ADDR = 8'h11;
  localparam logic [7:0] PWM_SAMPLE_CONFIG_ADDR = 8'h12;
  localparam logic [7:0] BRIGHTNESS_CODE_HIGH_ADDR = 8'h18;
  localparam logic [7:0] BRIGHTNESS_CODE_LOW_ADDR = 8'h19;

  // ****************************************
  // field positions, write masks, reset values
  // ****************************************
  localparam int CHIP_EN_BIT = 0;
  localparam int STRING_EN_LSB = 1;
  localparam int MODE_LSB = 5;
  localparam int EXP_MAP_BIT = 7;
  localparam int RATE_LSB = 6;
  localparam logic [7:0] ENABLE_CONTROL_MASK = 8'h07;
  localparam logic [7:0] BRIGHTNESS_CONFIG_MASK = 8'hE0;
  localparam logic [7:0] PWM_SAMPLE_CONFIG_MASK = 8'hC0;
  localparam logic [7:0] CODE_HIGH_MASK = 8'h07;
  localparam logic [7:0] ENABLE_CONTROL_RST = 8'h07;
  localparam logic [7:0] BRIGHTNESS_CONFIG_RST = 8'h20;
  localparam logic [7:0] PWM_SAMPLE_CONFIG_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;

  localparam int CODE_W = 11;
  localparam int CURRENT_W = 25;
  localparam logic [10:0] CODE_MAX = 11'h7FF;

  typedef enum logic [1:0] {
    MODE_REGISTER = 2'b00,
    MODE_PWM = 2'b01,
    MODE_PRODUCT = 2'b10,
    MODE_PRODUCT_ALT = 2'b11
  } bright_mode_e;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_800K_NS = 1250;
  localparam int SAMPLE_4M_NS = 250;
  localparam int SAMPLE_24M_NS = 42;
  localparam logic [7:0] SAMPLE_DIV_800K = 8'(SAMPLE_800K_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SAMPLE_DIV_4M = 8'(SAMPLE_4M_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SAMPLE_DIV_24M = 8'(SAMPLE_24M_NS / CLK_PERIOD_NS);
  localparam int RAMP_FULL_SCALE_US = 2000;
  localparam int RAMP_STEP_CYCLES = (RAMP_FULL_SCALE_US * 1000) / (2047 * CLK_PERIOD_NS);
  localparam int PWM_TIMEOUT_SAMPLES = 65535;

  // ****************************************
  // current mapping constants, nA
  // ****************************************
  localparam logic [24:0] LIN_OFFSET_NA = 25'd37806;
  localparam logic [24:0] LIN_SLOPE_NA = 25'd12195;
  localparam logic [47:0] EXP_BASE_NA = 48'd50000;
  // log2(1.003040572) in Q16
  localparam logic [19:0] EXP_LOG2_Q16 = 20'd287;

  typedef struct packed {
    logic chip_en;
    logic [1:0] string_en;
    bright_mode_e mode;
    logic exp_map;
    logic [1:0] rate;
  } ctrl_s;

  typedef struct packed {
    logic [10:0] code;
    logic exp_map;
    logic [1:0] sink_on;
  } sink_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_A = 3'b011,
    ST_REG = 3'b010,
    ST_ACK_R = 3'b110,
    ST_WR = 3'b111,
    ST_ACK_W = 3'b101,
    ST_RD = 3'b100
  } i2c_state_e;

endpackage

// ==== rtl/pwm_duty_meter.sv ====
// sampled PWM duty-cycle meter producing an 11-bit code
`timescale 1ns/100ps
module pwm_duty_meter #(
  parameter int TIMEOUT_SAMPLES = backlight_pkg::PWM_TIMEOUT_SAMPLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic sample_tick,
  input wire logic pwm_level,
  output logic [10:0] duty_code_q
);
  import backlight_pkg::*;

  logic prev_q;
  logic [19:0] high_q;
  logic [19:0] period_q;
  logic [19:0] rem_q;
  logic [19:0] den_q;
  logic [10:0] quo_q;
  logic [3:0] div_cnt_q;
  logic rise;
  logic [20:0] rem_sh;

  assign rise = sample_tick && pwm_level && !prev_q;
  assign rem_sh = {rem_q, 1'b0};

  // duty = high/period by restoring division, one quotient bit a cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q <= 1'b0;
      high_q <= '0;
      period_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      div_cnt_q <= '0;
      duty_code_q <= '0;
    end
    else if (!enable)
    begin
      prev_q <= 1'b0;
      high_q <= '0;
      period_q <= '0;
      den_q <= '0;
      div_cnt_q <= '0;
      duty_code_q <= '0;
    end
    else
    begin
      if (sample_tick)
        prev_q <= pwm_level;
      if (rise && period_q != '0)
      begin
        rem_q <= high_q;
        den_q <= period_q;
        quo_q <= '0;
        div_cnt_q <= 4'd11;
        high_q <= 20'd1;
        period_q <= 20'd1;
      end
      else if (sample_tick)
      begin
        // no edge for too long: a steady level means 0% or 100%
        if (period_q >= 20'(TIMEOUT_SAMPLES))
        begin
          duty_code_q <= pwm_level ? CODE_MAX : 11'h000;
          high_q <= '0;
          period_q <= '0;
        end
        else
        begin
          period_q <= period_q + 20'd1;
          high_q <= high_q + 20'(pwm_level);
        end
      end
      if (div_cnt_q != '0)
      begin
        if (rem_sh >= {1'b0, den_q})
        begin
          rem_q <= 20'(rem_sh - {1'b0, den_q});
          quo_q <= {quo_q[9:0], 1'b1};
        end
        else
        begin
          rem_q <= rem_sh[19:0];
          quo_q <= {quo_q[9:0], 1'b0};
        end
        div_cnt_q <= div_cnt_q - 4'd1;
      end
      else if (den_q != '0 && !(rise && period_q != '0))
      begin
        // high == period gives a 2048 result; clamp to full scale
        duty_code_q <= (rem_q == den_q) ? CODE_MAX : quo_q;
        den_q <= '0;
      end
    end
  end

endmodule

// ==== rtl/brightness_ramper.sv ====
// ramper slewing the applied code toward the selected target
`timescale 1ns/100ps
module brightness_ramper #(
  parameter int STEP_CYCLES = backlight_pkg::RAMP_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic [10:0] target,
  output logic [10:0] code_q
);
  import backlight_pkg::*;

  logic [15:0] tick_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_q <= '0;
      code_q <= '0;
    end
    else if (clear)
    begin
      tick_q <= '0;
      code_q <= '0;
    end
    else if (tick_q >= 16'(STEP_CYCLES - 1))
    begin
      tick_q <= '0;
      // one code per step: full scale takes about 2 ms
      if (code_q < target)
        code_q <= code_q + 11'd1;
      else if (code_q > target)
        code_q <= code_q - 11'd1;
    end
    else
      tick_q <= tick_q + 16'd1;
  end

  // a clear drops the code at once; only the following edge is exempt
  AST_RAMP_ONE_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!$past(clear) && code_q != $past(code_q)) |-> ((code_q - $past(code_q)) == 11'd1 ||
    ($past(code_q) - code_q) == 11'd1))
    else $error("ramper jumped by more than one code");

endmodule

// ==== rtl/backlight_brightness_control.sv ====
// top: enable, register file over I2C, brightness source select, ramp and current mapping
`timescale 1ns/100ps
module backlight_brightness_control #(
  // arbitrary default, set per board
  parameter logic [6:0] I2C_ADDR = 7'h2A,
  parameter int RAMP_STEP = backlight_pkg::RAMP_STEP_CYCLES,
  parameter int PWM_TIMEOUT = backlight_pkg::PWM_TIMEOUT_SAMPLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hw_master_enable_pin,
  input wire logic pwm_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_q,
  output backlight_pkg::sink_s sink_out_q,
  output logic [backlight_pkg::CURRENT_W-1:0] led_current_na_q,
  output logic shutdown_q,
  output logic standby_q
);
  import backlight_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] i2c_prev_q;
  logic hw_master_enable_pin_s;
  logic pwm_s;
  logic scl_s;
  logic sda_s;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // bus lines idle high: no false edge seen once reset lets go
      sync1_q <= 4'h3;
      sync2_q <= 4'h3;
      i2c_prev_q <= 2'b11;
    end
    else
    begin
      sync1_q <= {hw_master_enable_pin, pwm_in, scl_in, sda_in};
      sync2_q <= sync1_q;
      i2c_prev_q <= sync2_q[1:0];
    end
  end

  assign hw_master_enable_pin_s = sync2_q[3];
  assign pwm_s = sync2_q[2];
  assign scl_s = sync2_q[1];
  assign sda_s = sync2_q[0];

  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;

  assign scl_rise = scl_s && !i2c_prev_q[1];
  assign scl_fall = !scl_s && i2c_prev_q[1];
  assign i2c_start = scl_s && i2c_prev_q[1] && !sda_s && i2c_prev_q[0];
  assign i2c_stop = scl_s && i2c_prev_q[1] && sda_s && !i2c_prev_q[0];

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] enable_control_q;
  logic [7:0] brightness_config_q;
  logic [7:0] pwm_sample_config_q;
  logic [7:0] brightness_code_high_q;
  logic [7:0] brightness_code_low_q;
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  ctrl_s ctrl;
  logic [10:0] reg_code;

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      ENABLE_CONTROL_ADDR: val = enable_control_q;
      BRIGHTNESS_CONFIG_ADDR: val = brightness_config_q;
      PWM_SAMPLE_CONFIG_ADDR: val = pwm_sample_config_q;
      BRIGHTNESS_CODE_HIGH_ADDR: val = brightness_code_high_q;
      BRIGHTNESS_CODE_LOW_ADDR: val = brightness_code_low_q;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_control_q <= ENABLE_CONTROL_RST;
      brightness_config_q <= BRIGHTNESS_CONFIG_RST;
      pwm_sample_config_q <= PWM_SAMPLE_CONFIG_RST;
      brightness_code_high_q <= CODE_RST;
      brightness_code_low_q <= CODE_RST;
    end
    else if (!hw_master_enable_pin_s)
    begin
      enable_control_q <= ENABLE_CONTROL_RST;
      brightness_config_q <= BRIGHTNESS_CONFIG_RST;
      pwm_sample_config_q <= PWM_SAMPLE_CONFIG_RST;
      brightness_code_high_q <= CODE_RST;
      brightness_code_low_q <= CODE_RST;
    end
    else if (wr_q)
    begin
      // standby leaves every value untouched; only writes and a low enable pin (which restores the reset values) change them
      case (wr_addr_q)
        ENABLE_CONTROL_ADDR: enable_control_q <= wr_data_q & ENABLE_CONTROL_MASK;
        BRIGHTNESS_CONFIG_ADDR: brightness_config_q <= wr_data_q & BRIGHTNESS_CONFIG_MASK;
        PWM_SAMPLE_CONFIG_ADDR: pwm_sample_config_q <= wr_data_q & PWM_SAMPLE_CONFIG_MASK;
        BRIGHTNESS_CODE_HIGH_ADDR: brightness_code_high_q <= wr_data_q & CODE_HIGH_MASK;
        BRIGHTNESS_CODE_LOW_ADDR: brightness_code_low_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  assign ctrl.chip_en = enable_control_q[CHIP_EN_BIT];
  assign ctrl.string_en = enable_control_q[STRING_EN_LSB +: 2];
  assign ctrl.mode = bright_mode_e'(brightness_config_q[MODE_LSB +: 2]);
  assign ctrl.exp_map = brightness_config_q[EXP_MAP_BIT];
  assign ctrl.rate = pwm_sample_config_q[RATE_LSB +: 2];
  assign reg_code = {brightness_code_high_q[2:0], brightness_code_low_q};

  // ****************************************
  // I2C target
  // ****************************************
  i2c_state_e st_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic rw_q;

  // the bus is ignored entirely while the enable pin is low
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      ptr_q <= '0;
      tx_q <= '0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end
    else if (!hw_master_enable_pin_s)
    begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      sda_oe_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      if (i2c_stop)
      begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (i2c_start)
      begin
        st_q <= ST_ADDR;
        bit_q <= '0;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_q)
          ST_ADDR, ST_REG, ST_WR:
          begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end
          ST_RD:
          begin
            if (bit_q != 4'd8)
              bit_q <= bit_q + 4'd1;
            else if (sda_s)
              st_q <= ST_IDLE;
            else
            begin
              ptr_q <= ptr_q + 8'd1;
              tx_q <= read_reg(ptr_q + 8'd1);
              bit_q <= '0;
            end
          end
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_q)
          ST_ADDR:
          begin
            if (bit_q == 4'd8)
            begin
              if (shift_q[7:1] == I2C_ADDR)
              begin
                st_q <= ST_ACK_A;
                rw_q <= shift_q[0];
                tx_q <= read_reg(ptr_q);
                sda_oe_q <= 1'b1;
              end
              else
                st_q <= ST_IDLE;
            end
          end
          ST_ACK_A:
          begin
            bit_q <= '0;
            st_q <= rw_q ? ST_RD : ST_REG;
            sda_oe_q <= rw_q ? !tx_q[7] : 1'b0;
          end
          ST_REG:
          begin
            if (bit_q == 4'd8)
            begin
              ptr_q <= shift_q;
              st_q <= ST_ACK_R;
              sda_oe_q <= 1'b1;
            end
          end
          ST_ACK_R, ST_ACK_W:
          begin
            bit_q <= '0;
            st_q <= ST_WR;
            sda_oe_q <= 1'b0;
          end
          ST_WR:
          begin
            if (bit_q == 4'd8)
            begin
              wr_q <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= shift_q;
              ptr_q <= ptr_q + 8'd1;
              st_q <= ST_ACK_W;
              sda_oe_q <= 1'b1;
            end
          end
          ST_RD:
          begin
            if (bit_q < 4'd8)
              sda_oe_q <= !tx_q[3'(4'd7 - bit_q)];
            else
              sda_oe_q <= 1'b0;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      sda_out_q <= 1'b0;
    else
      sda_out_q <= 1'b0;
  end

  // ****************************************
  // PWM sampling and source selection
  // ****************************************
  logic [7:0] sdiv_q;
  logic sample_tick_q;
  logic [7:0] sdiv_max;
  logic [10:0] duty_code;
  logic [10:0] target;
  logic [10:0] ramp_code;
  logic dev_on;
  logic [21:0] product;

  assign sdiv_max = (ctrl.rate == 2'b00) ? SAMPLE_DIV_800K :
                    (ctrl.rate == 2'b01) ? SAMPLE_DIV_4M : SAMPLE_DIV_24M;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdiv_q <= '0;
      sample_tick_q <= 1'b0;
    end
    else if (sdiv_q >= sdiv_max - 8'd1)
    begin
      sdiv_q <= '0;
      sample_tick_q <= 1'b1;
    end
    else
    begin
      sdiv_q <= sdiv_q + 8'd1;
      sample_tick_q <= 1'b0;
    end
  end

  assign dev_on = hw_master_enable_pin_s && ctrl.chip_en;

  pwm_duty_meter #(
    .TIMEOUT_SAMPLES(PWM_TIMEOUT)
  ) u_meter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(dev_on),
    .sample_tick(sample_tick_q),
    .pwm_level(pwm_s),
    .duty_code_q(duty_code)
  );

  assign product = 22'(reg_code) * 22'(duty_code);

  always_comb
  begin
    case (ctrl.mode)
      MODE_REGISTER: target = reg_code;
      MODE_PWM: target = duty_code;
      default: target = product[21:11];
    endcase
  end

  brightness_ramper #(
    .STEP_CYCLES(RAMP_STEP)
  ) u_ramp (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(!dev_on),
    .target(target),
    .code_q(ramp_code)
  );

  // ****************************************
  // current mapping and sink drive
  // ****************************************
  function automatic logic [24:0] lin_current(input logic [10:0] code);
    return 25'(LIN_OFFSET_NA + LIN_SLOPE_NA * 25'(code));
  endfunction

  // 2^frac taken as 1+frac: a few percent high mid-octave, exact at octave points
  function automatic logic [24:0] exp_current(input logic [10:0] code);
    logic [19:0] e;
    logic [47:0] m;
    e = 20'(code) * EXP_LOG2_Q16;
    m = EXP_BASE_NA * (48'h10000 + 48'(e[15:0]));
    m = m << e[19:16];
    return m[40:16];
  endfunction

  logic [1:0] sink_on_d;

  assign sink_on_d = dev_on ? ctrl.string_en : 2'b00;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sink_out_q <= '0;
      led_current_na_q <= '0;
      shutdown_q <= 1'b1;
      standby_q <= 1'b0;
    end
    else
    begin
      sink_out_q.sink_on <= sink_on_d;
      sink_out_q.code <= (sink_on_d != 2'b00) ? ramp_code : 11'h000;
      sink_out_q.exp_map <= ctrl.exp_map;
      if (sink_on_d == 2'b00 || ramp_code == 11'h000)
        led_current_na_q <= '0;
      else if (ctrl.exp_map)
        led_current_na_q <= exp_current(ramp_code);
      else
        led_current_na_q <= lin_current(ramp_code);
      shutdown_q <= !dev_on;
      standby_q <= dev_on && (ctrl.string_en == 2'b00 ||
                   (target == 11'h000 && ramp_code == 11'h000));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sinks_dark;
    (sink_out_q.sink_on == 2'b00 && led_current_na_q == '0) [*2];
  endsequence

  AST_PIN_LOW_DEFAULTS: assert property (!hw_master_enable_pin_s |=>
    enable_control_q == ENABLE_CONTROL_RST &&
    brightness_config_q == BRIGHTNESS_CONFIG_RST && reg_code == 11'h000)
    else $error("registers not at defaults while enable pin low");
  AST_PIN_LOW_BUS_QUIET: assert property (!hw_master_enable_pin_s |=> !sda_oe_q && !wr_q)
    else $error("bus active while enable pin low");
  AST_CHIP_OFF_DARK: assert property ((!ctrl.chip_en && $past(!ctrl.chip_en)) |->
    s_sinks_dark)
    else $error("current flows with chip enable low");
  AST_STRING_FOLLOW: assert property (dev_on |=> sink_out_q.sink_on == $past(ctrl.string_en))
    else $error("sink enables do not follow string bits");
  AST_ZERO_CODE_ZERO_I: assert property (sink_out_q.code == 11'h000 |->
    led_current_na_q == '0)
    else $error("zero code with non-zero current");
  AST_LINEAR_MAP: assert property (!$past(ctrl.exp_map) && sink_out_q.code != 11'h000 |->
    led_current_na_q == 25'(LIN_OFFSET_NA + LIN_SLOPE_NA * 25'(sink_out_q.code)))
    else $error("linear current mismatch");
  AST_PRODUCT_SRC: assert property (ctrl.mode[1] |-> target ==
    11'((22'(reg_code) * 22'(duty_code)) >> 11))
    else $error("product source wrong");
  AST_ZERO_STANDBY: assert property ((dev_on && target == 11'h000 && ramp_code == 11'h000)
    |=> standby_q && led_current_na_q == '0)
    else $error("zero source not in standby");
  // the pin may rise again at once, so only the following cycle is certain
  AST_SHUTDOWN_FLAG: assert property (!hw_master_enable_pin_s |=> shutdown_q && !standby_q &&
    sink_out_q.sink_on == 2'b00)
    else $error("shutdown not flagged");

endmodule

// ==== sim/i2c_pwm_host.sv ====
// partner model: I2C host and PWM duty source facing the backlight control
`timescale 1ns/100ps
module i2c_pwm_host #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic core_clk,
  input wire logic sda_wire,
  output logic scl_q,
  output logic sda_low_q,
  output logic pwm_q
);
  int pwm_period = 0;
  int pwm_high = 0;
  int ph = 0;
  initial
  begin
    scl_q = 1'b1;
    sda_low_q = 1'b0;
    pwm_q = 1'b0;
  end
  // period 0 gives a constant level: high when pwm_high is non-zero
  always @(posedge core_clk)
  begin
    ph <= (ph + 1 >= pwm_period) ? 0 : ph + 1;
    pwm_q <= (ph < pwm_high);
  end
  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask
  // data moves a few cycles after scl falls so no false start is seen
  task automatic bit_x(input logic b, output logic r);
    repeat (3) @(posedge core_clk);
    sda_low_q <= ~b;
    half();
    scl_q <= 1'b1;
    half();
    r = sda_wire;
    scl_q <= 1'b0;
  endtask
  task automatic start();
    repeat (3) @(posedge core_clk);
    sda_low_q <= 1'b0;
    half();
    scl_q <= 1'b1;
    half();
    sda_low_q <= 1'b1;
    half();
    scl_q <= 1'b0;
  endtask
  task automatic stop();
    repeat (3) @(posedge core_clk);
    sda_low_q <= 1'b1;
    half();
    scl_q <= 1'b1;
    half();
    sda_low_q <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ai, a);
  endtask
  // nak high means some byte went unacknowledged
  task automatic write_reg(input logic [7:0] r, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(r, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask
  task automatic read_reg(input logic [7:0] r, output logic [7:0] q, output logic nak);
    logic a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(r, 1'b1, q, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b1, q, a3);
    stop();
    nak = a0 | a1 | a2;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// testbench: enable, register access, source select, ramp and mapping of the backlight control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import backlight_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_en = 1'b0;
  logic scl, sda_low, pwm, sda_oe, sda_out, shutdown, standby, nak;
  logic [7:0] rd;
  logic [CURRENT_W-1:0] cur;
  sink_s sink;
  wire logic sda_wire = ~(sda_low | sda_oe);
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // timeout must outlast one 800-cycle PWM period at every sample rate used
  backlight_brightness_control #(.I2C_ADDR(7'h2A), .RAMP_STEP(2), .PWM_TIMEOUT(512)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .hw_master_enable_pin(pin_en), .pwm_in(pwm),
    .scl_in(scl), .sda_in(sda_wire), .sda_out_q(sda_out), .sda_oe_q(sda_oe),
    .sink_out_q(sink), .led_current_na_q(cur), .shutdown_q(shutdown), .standby_q(standby));
  i2c_pwm_host #(.ADDR(7'h2A)) host (
    .core_clk(core_clk), .sda_wire(sda_wire), .scl_q(scl), .sda_low_q(sda_low), .pwm_q(pwm));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ceiling well above the roughly 40k cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, nak);
    `CHK("wr_ack", 1'b0, nak)
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, rd, nak);
    `CHK("rd_ack", 1'b0, nak)
    `CHK("rd_data", e, rd)
  endtask
  initial
  begin
    wait_cyc(8);
    reset_n <= 1'b1;
    wait_cyc(4);
    `CHK("shdn_pin_low", 1'b1, shutdown)
    host.read_reg(BRIGHTNESS_CONFIG_ADDR, rd, nak);
    `CHK("nak_pin_low", 1'b1, nak)
    pin_en <= 1'b1;
    wait_cyc(8);
    rdchk(ENABLE_CONTROL_ADDR, 8'h07);
    rdchk(BRIGHTNESS_CONFIG_ADDR, 8'h20);
    rdchk(BRIGHTNESS_CODE_LOW_ADDR, 8'h00);
    rdchk(8'h20, 8'h00);
    `CHK("shdn", 1'b0, shutdown)
    `CHK("stby_pwm0", 1'b1, standby)
    `CHK("sda_out", 1'b0, sda_out)
    wr(PWM_SAMPLE_CONFIG_ADDR, 8'h7F);
    rdchk(PWM_SAMPLE_CONFIG_ADDR, 8'h40);
    host.pwm_period = 800;
    host.pwm_high = 200;
    wait_cyc(4000);
    `CHK("pwm_code_4m", 11'd512, sink.code)
    wr(PWM_SAMPLE_CONFIG_ADDR, 8'hC0);
    host.pwm_high = 400;
    wait_cyc(6000);
    `CHK("pwm_code", 1'b1, sink.code > 11'd1000 && sink.code < 11'd1050)
    `CHK("stby_off", 1'b0, standby)
    wr(BRIGHTNESS_CODE_HIGH_ADDR, 8'h04);
    for (int m = 2; m < 4; m++)
    begin
      wr(BRIGHTNESS_CONFIG_ADDR, 8'(m << 5));
      wait_cyc(3000);
      `CHK("product", 1'b1, sink.code > 11'd495 && sink.code < 11'd530)
    end
    wr(BRIGHTNESS_CODE_LOW_ADDR, 8'hFF);
    wr(BRIGHTNESS_CONFIG_ADDR, 8'h00);
    `CHK("ramping", 1'b1, sink.code !== 11'h4FF)
    wait_cyc(3000);
    `CHK("reg_code", 11'h4FF, sink.code)
    `CHK("sinks_on", 2'b11, sink.sink_on)
    `CHK("lin_cur", 25'(37806 + 12195 * 1279), cur)
    wr(BRIGHTNESS_CONFIG_ADDR, 8'h80);
    wait_cyc(10);
    `CHK("exp_sel", 1'b1, sink.exp_map)
    `CHK("exp_cur", 1'b1, cur > 25'd2200000 && cur < 25'd2700000)
    wr(BRIGHTNESS_CODE_HIGH_ADDR, 8'h00);
    wr(BRIGHTNESS_CODE_LOW_ADDR, 8'h00);
    wait_cyc(3000);
    `CHK("zero_cur", 25'd0, cur)
    `CHK("zero_stby", 1'b1, standby)
    wr(BRIGHTNESS_CODE_LOW_ADDR, 8'h80);
    wait_cyc(500);
    wr(ENABLE_CONTROL_ADDR, 8'h01);
    wait_cyc(10);
    `CHK("str_off", 2'b00, sink.sink_on)
    `CHK("str_cur", 25'd0, cur)
    `CHK("str_stby", 1'b1, standby)
    rdchk(BRIGHTNESS_CODE_LOW_ADDR, 8'h80);
    wr(ENABLE_CONTROL_ADDR, 8'h06);
    wait_cyc(10);
    `CHK("chip_off", 1'b1, shutdown)
    `CHK("chip_cur", 25'd0, cur)
    pin_en <= 1'b0;
    host.pwm_period = 0;
    host.pwm_high = 0;
    wait_cyc(8);
    `CHK("pin_shdn", 1'b1, shutdown)
    pin_en <= 1'b1;
    wait_cyc(8);
    rdchk(BRIGHTNESS_CODE_LOW_ADDR, 8'h00);
    rdchk(ENABLE_CONTROL_ADDR, 8'h07);
    `CHK("pwm_low_stby", 1'b1, standby)
    `CHK("pwm_low_cur", 25'd0, cur)
    final_report();
  end
endmodule
